// ==== rtl/synth_chip_pkg.sv ====
// Purpose: Shared constants for the single-channel synthesizer chip core
// Assumes: One clock at 200 MHz; serial pins sampled synchronously
// Notes: Register addresses and widths are fixed by this core's own map
package synth_chip_pkg;
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_RAMP_CFG = 5'h01;
   localparam logic [4:0] ADDR_LIMITS = 5'h0B;
   localparam logic [4:0] ADDR_STEPS = 5'h0C;
   localparam logic [4:0] ADDR_RATES = 5'h0D;
   localparam logic [4:0] ADDR_PROF_FIRST = 5'h0E;
   localparam logic [4:0] ADDR_PROF_LAST = 5'h15;
   localparam logic [3:0] BYTES_SHORT = 4'h4;
   localparam logic [3:0] BYTES_LONG = 4'h8;
   localparam logic [3:0] BYTES_NONE = 4'h0;
   localparam int INSTR_READ_BIT = 7;
   localparam int CTRL_PD_BIT = 7;
   localparam int RAMP_EN_BIT = 19;
   localparam int RAMP_DEST_LSB = 20;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] RAMP_CFG_RST = 32'h0000_0000;
   localparam logic [1:0] DEST_FREQ = 2'h0;
   localparam logic [1:0] DEST_PHASE = 2'h1;
   localparam logic [1:0] DEST_AMPL = 2'h2;
   localparam logic [6:0] INSTR_BITS = 7'h08;
   localparam int PROF_DEPTH = 8;
   localparam int PROF_WIDTH = 64;
   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_INSTR = 2'b01,
      SER_DATA = 2'b11
   } ser_state_type;
endpackage : synth_chip_pkg

// ==== rtl/profile_mem.sv ====
// Purpose: Eight single-tone profile words with registered read
// Assumes: One write port, one read port, same clock
// Notes: Contents are not cleared by reset; validity is tracked outside
`timescale 1ns/1ps
module profile_mem
(
   // Clock
   input wire logic clk_in,
   // Write side
   input wire logic wr_en_in,
   input wire logic [2:0] wr_addr_in,
   input wire logic [63:0] wr_data_in,
   // Read side
   input wire logic [2:0] rd_addr_in,
   output logic [63:0] rd_data_out
);
   logic [63:0] mem_ff [synth_chip_pkg::PROF_DEPTH];

   always_ff @(posedge clk_in)
   begin
      if (wr_en_in)
      begin
         mem_ff[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in)
   begin
      rd_data_out <= mem_ff[rd_addr_in];
   end
endmodule : profile_mem

// ==== rtl/synth_chip_core.sv ====
// Purpose: Serial-programmed synthesizer channel: buffer, commit, ramp
// Assumes: Serial clock and selects are synchronous to clk_in
// Notes: Amplitude ramp is linear in the amplitude code only
`timescale 1ns/1ps
// What this block does
// - During a ramp, non-destination outputs come from the active profile.
// - Amplitude ramp steps linearly in amplitude code; no power-linear mode.
// - Buffer reset drops partial serial data, keeps stored registers.
// - Commit strobe moves buffered data into active registers.
// - Master reset restores defaults and discards all user data.
// - Waking from power-down restores prior state with data intact.
// - Reinit works even while powered down; any reinit clears power-down.
// - Profile reads return only the profile chosen by the select pins.
module synth_chip_core
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Serial port
   input wire logic select_line_n_in,
   input wire logic sclk_in,
   input wire logic sdio_in,
   output logic sdo_out,
   // Control pins
   input wire logic shared_buffer_reset_line_in,
   input wire logic commit_strobe_in,
   input wire logic hard_reset_in,
   input wire logic [2:0] profile_sel_in,
   input wire logic ramp_up_in,
   // Synthesis words and status flags
   output logic [31:0] ftw_out,
   output logic [15:0] pow_out,
   output logic [13:0] asf_out,
   output logic powered_down_out,
   output logic ramp_active_out
);
   synth_chip_pkg::ser_state_type ser_state_ff;
   logic sclk_ff;
   logic [6:0] bit_cnt_ff;
   logic [4:0] addr_ff;
   logic rd_ff;
   logic [63:0] shift_ff;
   logic [63:0] rd_sh_ff;
   logic pend_valid_ff;
   logic [4:0] pend_addr_ff;
   logic [63:0] pend_data_ff;
   logic [31:0] ctrl_ff;
   logic [31:0] ramp_cfg_ff;
   logic [63:0] limits_ff;
   logic [63:0] steps_ff;
   logic [31:0] rates_ff;
   logic [7:0] prof_valid_ff;
   logic [2:0] sel_ff;
   logic [31:0] acc_ff;
   logic [15:0] rate_cnt_ff;
   logic [63:0] prof_rd;
   logic [63:0] act_word;
   logic sclk_rise;
   logic sclk_fall;
   logic commit;
   logic prof_wr;
   logic pd;
   logic ramp_en;
   logic [1:0] dest;
   logic [3:0] nbytes;
   logic [32:0] up_sum;
   logic [32:0] lo_sum;
   logic [15:0] nxt_rate;

   localparam logic [6:0] INSTR_LAST = synth_chip_pkg::INSTR_BITS - 7'h01;

   function automatic logic [3:0] reg_bytes(input logic [4:0] a);
      if (a == synth_chip_pkg::ADDR_CTRL || a == synth_chip_pkg::ADDR_RAMP_CFG
          || a == synth_chip_pkg::ADDR_RATES)
         reg_bytes = synth_chip_pkg::BYTES_SHORT;
      else if (a == synth_chip_pkg::ADDR_LIMITS
               || a == synth_chip_pkg::ADDR_STEPS
               || (a >= synth_chip_pkg::ADDR_PROF_FIRST
                   && a <= synth_chip_pkg::ADDR_PROF_LAST))
         reg_bytes = synth_chip_pkg::BYTES_LONG;
      else
         reg_bytes = synth_chip_pkg::BYTES_NONE;
   endfunction : reg_bytes

   function automatic logic is_prof(input logic [4:0] a);
      is_prof = (a >= synth_chip_pkg::ADDR_PROF_FIRST)
                && (a <= synth_chip_pkg::ADDR_PROF_LAST);
   endfunction : is_prof

   assign sclk_rise = sclk_in && !sclk_ff && !select_line_n_in;
   assign sclk_fall = !sclk_in && sclk_ff && !select_line_n_in;
   assign nbytes = reg_bytes(addr_ff);
   assign commit = commit_strobe_in && pend_valid_ff;
   assign prof_wr = commit && is_prof(pend_addr_ff);
   assign pd = ctrl_ff[synth_chip_pkg::CTRL_PD_BIT];
   assign ramp_en = ramp_cfg_ff[synth_chip_pkg::RAMP_EN_BIT];
   assign dest = ramp_cfg_ff[synth_chip_pkg::RAMP_DEST_LSB +: 2];
   assign act_word = prof_valid_ff[sel_ff] ? prof_rd : '0;
   assign sdo_out = rd_sh_ff[63];
   assign powered_down_out = pd;
   assign ramp_active_out = ramp_en && !pd;

   profile_mem u_prof
   (
      .clk_in(clk_in),
      .wr_en_in(prof_wr),
      .wr_addr_in(3'(pend_addr_ff - synth_chip_pkg::ADDR_PROF_FIRST)),
      .wr_data_in(pend_data_ff),
      .rd_addr_in(profile_sel_in),
      .rd_data_out(prof_rd)
   );

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         sclk_ff <= 1'b0;
      else
         sclk_ff <= sclk_in;
   end

   // Serial receive; buffer reset only touches the shifter, never registers
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ser_state_ff <= synth_chip_pkg::SER_IDLE;
         bit_cnt_ff <= '0;
         addr_ff <= '0;
         rd_ff <= 1'b0;
         shift_ff <= '0;
      end
      else if (shared_buffer_reset_line_in || hard_reset_in
               || select_line_n_in)
      begin
         ser_state_ff <= synth_chip_pkg::SER_IDLE;
         bit_cnt_ff <= '0;
         shift_ff <= '0;
      end
      else if (sclk_rise)
      begin
         shift_ff <= {shift_ff[62:0], sdio_in};
         bit_cnt_ff <= bit_cnt_ff + 7'h01;
         case (ser_state_ff)
            synth_chip_pkg::SER_IDLE:
            begin
               ser_state_ff <= synth_chip_pkg::SER_INSTR;
               bit_cnt_ff <= 7'h01;
            end
            synth_chip_pkg::SER_INSTR:
            begin
               if (bit_cnt_ff == INSTR_LAST)
               begin
                  ser_state_ff <= synth_chip_pkg::SER_DATA;
                  rd_ff <= shift_ff[synth_chip_pkg::INSTR_READ_BIT - 1];
                  addr_ff <= {shift_ff[3:0], sdio_in};
                  bit_cnt_ff <= '0;
               end
            end
            default:
            begin
               // Exact width ends the frame; extra bits start a new instruction
               if (bit_cnt_ff == {nbytes, 3'h0} - 7'h01)
               begin
                  ser_state_ff <= synth_chip_pkg::SER_IDLE;
               end
            end
         endcase
      end
   end

   // Completed write frame waits in the buffer until committed
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pend_valid_ff <= 1'b0;
         pend_addr_ff <= '0;
         pend_data_ff <= '0;
      end
      else if (hard_reset_in)
         pend_valid_ff <= 1'b0;
      else if (sclk_rise && ser_state_ff == synth_chip_pkg::SER_DATA && !rd_ff
               && nbytes != synth_chip_pkg::BYTES_NONE
               && bit_cnt_ff == {nbytes, 3'h0} - 7'h01)
      begin
         pend_valid_ff <= 1'b1;
         pend_addr_ff <= addr_ff;
         pend_data_ff <= {shift_ff[62:0], sdio_in};
      end
      else if (commit)
         pend_valid_ff <= 1'b0;
   end

   // Read data: profile addresses answer with the pin-selected profile
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         rd_sh_ff <= '0;
      else if (ser_state_ff == synth_chip_pkg::SER_DATA && rd_ff
               && bit_cnt_ff == 7'h00 && sclk_fall)
      begin
         if (is_prof(addr_ff))
            rd_sh_ff <= act_word;
         else if (addr_ff == synth_chip_pkg::ADDR_CTRL)
            rd_sh_ff <= {ctrl_ff, 32'h0000_0000};
         else if (addr_ff == synth_chip_pkg::ADDR_RAMP_CFG)
            rd_sh_ff <= {ramp_cfg_ff, 32'h0000_0000};
         else if (addr_ff == synth_chip_pkg::ADDR_LIMITS)
            rd_sh_ff <= limits_ff;
         else if (addr_ff == synth_chip_pkg::ADDR_STEPS)
            rd_sh_ff <= steps_ff;
         else if (addr_ff == synth_chip_pkg::ADDR_RATES)
            rd_sh_ff <= {rates_ff, 32'h0000_0000};
         else
            rd_sh_ff <= '0;
      end
      else if (sclk_fall && ser_state_ff == synth_chip_pkg::SER_DATA)
         rd_sh_ff <= {rd_sh_ff[62:0], 1'b0};
   end

   // Active registers: commit copies the buffer, master reset restores
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctrl_ff <= synth_chip_pkg::CTRL_RST;
         ramp_cfg_ff <= synth_chip_pkg::RAMP_CFG_RST;
         limits_ff <= '0;
         steps_ff <= '0;
         rates_ff <= '0;
         prof_valid_ff <= '0;
      end
      else if (hard_reset_in)
      begin
         ctrl_ff <= synth_chip_pkg::CTRL_RST;
         ramp_cfg_ff <= synth_chip_pkg::RAMP_CFG_RST;
         limits_ff <= '0;
         steps_ff <= '0;
         rates_ff <= '0;
         prof_valid_ff <= '0;
      end
      else if (commit)
      begin
         if (pend_addr_ff == synth_chip_pkg::ADDR_CTRL)
            ctrl_ff <= pend_data_ff[31:0];
         else if (pend_addr_ff == synth_chip_pkg::ADDR_RAMP_CFG)
            ramp_cfg_ff <= pend_data_ff[31:0];
         else if (pend_addr_ff == synth_chip_pkg::ADDR_LIMITS)
            limits_ff <= pend_data_ff;
         else if (pend_addr_ff == synth_chip_pkg::ADDR_STEPS)
            steps_ff <= pend_data_ff;
         else if (pend_addr_ff == synth_chip_pkg::ADDR_RATES)
            rates_ff <= pend_data_ff[31:0];
         else if (prof_wr)
            prof_valid_ff[3'(pend_addr_ff - synth_chip_pkg::ADDR_PROF_FIRST)]
               <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         sel_ff <= '0;
      else
         sel_ff <= profile_sel_in;
   end

   // Ramp generator; frozen in power-down so wake resumes in place
   assign up_sum = {1'b0, acc_ff} + {1'b0, steps_ff[31:0]};
   assign lo_sum = {1'b0, limits_ff[31:0]} + {1'b0, steps_ff[63:32]};
   assign nxt_rate = ramp_up_in ? rates_ff[15:0] : rates_ff[31:16];
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         acc_ff <= '0;
         rate_cnt_ff <= '0;
      end
      else if (!ramp_en)
      begin
         acc_ff <= limits_ff[31:0];
         rate_cnt_ff <= '0;
      end
      else if (!pd)
      begin
         if (rate_cnt_ff != 16'h0000)
            rate_cnt_ff <= rate_cnt_ff - 16'h0001;
         else
         begin
            rate_cnt_ff <= nxt_rate;
            // Plain linear steps; amplitude follows the code, not dBm
            if (ramp_up_in)
               acc_ff <= (up_sum >= {1'b0, limits_ff[63:32]}) ?
                         limits_ff[63:32] : up_sum[31:0];
            else
               acc_ff <= ({1'b0, acc_ff} <= lo_sum) ?
                         limits_ff[31:0] : acc_ff - steps_ff[63:32];
         end
      end
   end

   // Output words: ramp drives its destination, profile drives the rest
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ftw_out <= '0;
         pow_out <= '0;
         asf_out <= '0;
      end
      else if (pd)
      begin
         ftw_out <= '0;
         pow_out <= '0;
         asf_out <= '0;
      end
      else
      begin
         ftw_out <= (ramp_en && dest == synth_chip_pkg::DEST_FREQ) ?
                    acc_ff : act_word[31:0];
         pow_out <= (ramp_en && dest == synth_chip_pkg::DEST_PHASE) ?
                    acc_ff[31:16] : act_word[47:32];
         asf_out <= (ramp_en && dest == synth_chip_pkg::DEST_AMPL) ?
                    acc_ff[31:18] : act_word[61:48];
      end
   end

   AST_BUF_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
      shared_buffer_reset_line_in && !commit && !hard_reset_in
      |=> bit_cnt_ff == 7'h00
      && ser_state_ff == synth_chip_pkg::SER_IDLE && $stable(ctrl_ff))
      else $error("buffer reset left partial frame or changed registers");
   AST_COMMIT: assert property (@(posedge clk_in) disable iff (rst_in)
      commit && !hard_reset_in && pend_addr_ff == synth_chip_pkg::ADDR_CTRL
      |=> ctrl_ff == $past(pend_data_ff[31:0]) && !pend_valid_ff)
      else $error("commit did not move buffer into control register");
   AST_NO_COMMIT: assert property (@(posedge clk_in) disable iff (rst_in)
      !commit_strobe_in && !hard_reset_in |=> $stable(ramp_cfg_ff))
      else $error("register changed without a commit strobe");
   AST_MASTER_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
      hard_reset_in |=> ctrl_ff == synth_chip_pkg::CTRL_RST
      && prof_valid_ff == 8'h00 && !pend_valid_ff)
      else $error("master reset kept user data");
   AST_REINIT_WAKES: assert property (@(posedge clk_in) disable iff (rst_in)
      hard_reset_in |=> !powered_down_out)
      else $error("reinit left the channel powered down");
   AST_PD_HOLDS: assert property (@(posedge clk_in) disable iff (rst_in)
      pd && $past(pd) && !hard_reset_in && !commit |=> $stable(acc_ff)
      && $stable(prof_valid_ff) && ftw_out == 32'h0000_0000)
      else $error("power-down lost state or drove output");
   AST_WAKE: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(pd) && !ramp_en ##1 !pd ##1 !pd
      |-> ftw_out == $past(act_word[31:0]))
      else $error("wake did not restore profile output");
   AST_RAMP_SIDE: assert property (@(posedge clk_in) disable iff (rst_in)
      ramp_en && !pd && dest == synth_chip_pkg::DEST_FREQ
      |=> pow_out == $past(act_word[47:32]))
      else $error("non-destination phase not from active profile");
   AST_AMPL_LINEAR: assert property (@(posedge clk_in) disable iff (rst_in)
      ramp_en && !pd && dest == synth_chip_pkg::DEST_AMPL
      |=> asf_out == $past(acc_ff[31:18]))
      else $error("amplitude ramp not linear in the code");
   AST_PROF_READ: assert property (@(posedge clk_in) disable iff (rst_in)
      sclk_fall && rd_ff && ser_state_ff == synth_chip_pkg::SER_DATA
      && bit_cnt_ff == 7'h00 && is_prof(addr_ff)
      |=> rd_sh_ff == $past(act_word))
      else $error("profile read not from selected profile");
   COV_COMMIT: cover property (@(posedge clk_in) disable iff (rst_in)
      commit);
   COV_RAMP: cover property (@(posedge clk_in) disable iff (rst_in)
      ramp_en && !pd && rate_cnt_ff == 16'h0000);
   COV_WAKE: cover property (@(posedge clk_in) disable iff (rst_in)
      $fell(pd));
endmodule : synth_chip_core

// ==== tb/synth_host_model.sv ====
// Purpose: Host controller model that programs four synthesizer channels
// Assumes: Pins change just after clk_in rises; sclk stands low idle
// Notes: Tasks are called from the testbench, one transfer at a time
`timescale 1ns/1ps
module synth_host_model
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Select lines, active low; line 0 is the shared buffer reset
   output logic [7:0] cs_n_out,
   // Digital lines: master resets, then commit strobes
   output logic [7:0] dio_out,
   // Serial port
   output logic sclk_out,
   output logic sdio_out,
   input wire logic sdo_in
);
   initial
   begin
      cs_n_out = 8'hFF;
      dio_out = 8'h00;
      sclk_out = 1'b0;
      sdio_out = 1'b0;
   end

   function automatic logic valid_ch(input int ch);
      return ch >= 1 && ch <= 4;
   endfunction : valid_ch

   // Byte count follows the addressed register
   function automatic int width_of(input logic [4:0] a);
      if (a == synth_chip_pkg::ADDR_CTRL || a == synth_chip_pkg::ADDR_RAMP_CFG
          || a == synth_chip_pkg::ADDR_RATES)
         return 4;
      return 8;
   endfunction : width_of

   task automatic frame(input int ch, input logic [7:0] instr,
      input logic [63:0] data, input int cut, output logic [63:0] rd);
      int nbits;
      logic [71:0] sh;
      nbits = 8 + 8 * width_of(instr[4:0]);
      sh = {instr, data << (72 - nbits)};
      rd = 64'h0;
      if (!valid_ch(ch) || rst_in)
         return;
      @(posedge clk_in);
      cs_n_out[5 - ch] <= 1'b0;
      for (int i = 0; i < nbits && i < cut; i++)
      begin
         @(posedge clk_in);
         sdio_out <= sh[71 - i];
         repeat (2) @(posedge clk_in);
         sclk_out <= 1'b1;
         rd = {rd[62:0], sdo_in};
         repeat (2) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      @(posedge clk_in);
      // Cut frames are flushed for every chip at once
      if (cut < nbits)
         cs_n_out[0] <= 1'b0;
      @(posedge clk_in);
      cs_n_out <= 8'hFF;
      // Released data line must not keep its last level
      sdio_out <= ~sdio_out;
   endtask : frame

   task automatic write_reg(input int ch, input logic [4:0] addr,
      input logic [63:0] data);
      logic [63:0] rd;
      frame(ch, {3'h0, addr}, data, 1000, rd);
   endtask : write_reg

   task automatic read_reg(input int ch, input logic [4:0] addr,
      output logic [63:0] rd);
      frame(ch, {3'h4, addr}, 64'h0, 1000, rd);
   endtask : read_reg

   task automatic commit(input int ch);
      if (!valid_ch(ch))
         return;
      @(posedge clk_in);
      dio_out[3 + ch] <= 1'b1;
      @(posedge clk_in);
      dio_out[3 + ch] <= 1'b0;
   endtask : commit

   task automatic reinit(input int ch);
      if (!valid_ch(ch))
         return;
      @(posedge clk_in);
      dio_out[4 - ch] <= 1'b1;
      @(posedge clk_in);
      dio_out[4 - ch] <= 1'b0;
      // Control and ramp config are written again with their zero reset values
      // Chip buffers one frame, so each write is committed on its own
      write_reg(ch, synth_chip_pkg::ADDR_CTRL, 64'h0);
      commit(ch);
      write_reg(ch, synth_chip_pkg::ADDR_RAMP_CFG, 64'h0);
      commit(ch);
   endtask : reinit
endmodule : synth_host_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for one synthesizer channel core
// Assumes: Core sits on channel 1 of the host model
// Notes: Ramp limits sit four steps apart so ramps settle quickly
`timescale 1ns/1ps
module testbench;
   logic clk_in;
   logic rst_in;
   logic [7:0] cs_n;
   logic [7:0] dio;
   logic sclk;
   logic sdio;
   logic sdo_out;
   logic [2:0] profile_sel_in;
   logic ramp_up_in;
   logic [31:0] ftw_out;
   logic [15:0] pow_out;
   logic [13:0] asf_out;
   logic powered_down_out;
   logic ramp_active_out;
   logic [63:0] rd;
   int n_mismatch;
   int n_compared;
   localparam logic [63:0] WORD_A = 64'h1ABC_2345_1234_5678;
   localparam logic [63:0] WORD_B = 64'h0123_4567_89AB_CDEF;
   localparam logic [31:0] LIMIT = 32'hA5A4_C3C0;

   always #2.5 clk_in = ~clk_in;

   synth_host_model synth_host_model_inst (.clk_in(clk_in), .rst_in(rst_in),
      .cs_n_out(cs_n), .dio_out(dio), .sclk_out(sclk), .sdio_out(sdio),
      .sdo_in(sdo_out));

   synth_chip_core synth_chip_core_inst (.clk_in(clk_in), .rst_in(rst_in),
      .select_line_n_in(cs_n[4]), .sclk_in(sclk), .sdio_in(sdio),
      .sdo_out(sdo_out), .shared_buffer_reset_line_in(~cs_n[0]),
      .commit_strobe_in(dio[4]), .hard_reset_in(dio[3]),
      .profile_sel_in(profile_sel_in), .ramp_up_in(ramp_up_in),
      .ftw_out(ftw_out), .pow_out(pow_out), .asf_out(asf_out),
      .powered_down_out(powered_down_out),
      .ramp_active_out(ramp_active_out));

   function automatic logic [4:0] prof_addr(input logic [2:0] n);
      return synth_chip_pkg::ADDR_PROF_FIRST + {2'h0, n};
   endfunction : prof_addr

   task automatic fail(input string what);
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
   endtask : fail

   // Outputs lag a commit by two edges; four leaves margin
   task automatic expect_out(input logic [63:0] w, input logic pd,
      input logic ra, input string what);
      repeat (4) @(posedge clk_in);
      #1;
      n_compared++;
      if (ftw_out !== w[31:0] || pow_out !== w[47:32]
          || asf_out !== w[61:48] || powered_down_out !== pd
          || ramp_active_out !== ra)
         fail(what);
   endtask : expect_out

   task automatic expect_read(input logic [4:0] a, input logic [63:0] w);
      synth_host_model_inst.read_reg(1, a, rd);
      n_compared++;
      if (rd !== w)
         fail("read data differs");
   endtask : expect_read

   task automatic set_sel(input logic [2:0] s);
      @(posedge clk_in);
      profile_sel_in <= s;
   endtask : set_sel

   task automatic t_profile;
      set_sel(3'h3);
      synth_host_model_inst.write_reg(1, prof_addr(3'h3), WORD_A);
      expect_out(64'h0, 1'b0, 1'b0, "output moved before commit");
      synth_host_model_inst.commit(1);
      expect_out(WORD_A, 1'b0, 1'b0, "profile 3 not loaded");
      synth_host_model_inst.write_reg(1, prof_addr(3'h5), WORD_B);
      synth_host_model_inst.write_reg(5, prof_addr(3'h3), 64'h0);
      synth_host_model_inst.write_reg(2, prof_addr(3'h3), 64'h0);
      synth_host_model_inst.commit(2);
      synth_host_model_inst.commit(1);
      expect_out(WORD_A, 1'b0, 1'b0, "profile 3 disturbed");
      set_sel(3'h5);
      expect_out(WORD_B, 1'b0, 1'b0, "profile 5 not selected");
      set_sel(3'h3);
      expect_read(prof_addr(3'h5), WORD_A);
      $display("TB: profile test done");
   endtask : t_profile

   task automatic t_abort;
      synth_host_model_inst.frame(1, {3'h0, prof_addr(3'h3)}, WORD_B, 30, rd);
      synth_host_model_inst.commit(1);
      expect_out(WORD_A, 1'b0, 1'b0, "cut frame took effect");
      synth_host_model_inst.write_reg(1, prof_addr(3'h3), WORD_B);
      synth_host_model_inst.commit(1);
      expect_out(WORD_B, 1'b0, 1'b0, "frame after flush lost");
      $display("TB: abort test done");
   endtask : t_abort

   task automatic t_power;
      synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_CTRL, 64'h80);
      synth_host_model_inst.commit(1);
      expect_out(64'h0, 1'b1, 1'b0, "power-down not entered");
      synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_CTRL, 64'h0);
      synth_host_model_inst.commit(1);
      expect_out(WORD_B, 1'b0, 1'b0, "wake lost state");
      $display("TB: power test done");
   endtask : t_power

   task automatic t_ramp;
      logic [1:0] dests [3];
      logic [63:0] w;
      dests = '{synth_chip_pkg::DEST_FREQ, synth_chip_pkg::DEST_PHASE,
         synth_chip_pkg::DEST_AMPL};
      for (int d = 0; d < 3; d++)
      begin
         // One pending frame at a time, so every write gets its commit
         synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_LIMITS,
            {LIMIT + 32'h0000_0004, LIMIT});
         synth_host_model_inst.commit(1);
         synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_STEPS,
            64'h0000_0001_0000_0001);
         synth_host_model_inst.commit(1);
         synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_RATES,
            64'h0);
         synth_host_model_inst.commit(1);
         synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_RAMP_CFG,
            {42'h0, dests[d], 1'b1, 19'h0});
         synth_host_model_inst.commit(1);
         repeat (20) @(posedge clk_in);
         w = WORD_B;
         if (d == 0)
            w[31:0] = LIMIT + 32'h0000_0004;
         else if (d == 1)
            w[47:32] = LIMIT[31:16];
         else
            w[61:48] = LIMIT[31:18];
         expect_out(w, 1'b0, 1'b1, "ramp outputs wrong");
         if (d == 0)
         begin
            @(posedge clk_in);
            ramp_up_in <= 1'b0;
            repeat (10) @(posedge clk_in);
            w[31:0] = LIMIT;
            expect_out(w, 1'b0, 1'b1, "ramp down missed lower limit");
            @(posedge clk_in);
            ramp_up_in <= 1'b1;
         end
      end
      synth_host_model_inst.write_reg(1, synth_chip_pkg::ADDR_RAMP_CFG, 64'h0);
      synth_host_model_inst.commit(1);
      expect_out(WORD_B, 1'b0, 1'b0, "ramp not stopped");
      $display("TB: ramp test done");
   endtask : t_ramp

   task automatic t_hard;
      synth_host_model_inst.reinit(1);
      expect_out(64'h0, 1'b0, 1'b0, "user data survived reset");
      expect_read(prof_addr(3'h3), 64'h0);
      $display("TB: hard reset test done");
   endtask : t_hard

   task automatic test_done;
      $display("TB: compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   initial
   begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      profile_sel_in = 3'h0;
      ramp_up_in = 1'b1;
      n_mismatch = 0;
      n_compared = 0;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      t_profile;
      t_abort;
      t_power;
      t_ramp;
      t_hard;
      test_done;
   end

   // About 25 frames of 400 cycles each; allow four times that
   initial
   begin
      #200000;
      fail("watchdog expired");
      test_done;
   end
endmodule : testbench
